// [core/eag_core.sv]
// eag_core: effective address generator with its address register bank.
// assumes decoder and memory bus logic on ref_clk; no pin synchronising.
`timescale 1ns/1ps

// Functional notes
// - drop upper eight bits of every 24-bit address; memory sees 16 bits.
// - arithmetic and logic operands only register direct or immediate.
// - data transfers allow all modes except pc relative and memory indirect.
// - bit operand direct, indirect or absolute; bit number reg or 3-bit.
// - register direct picks 32-bit register, 16-bit half or low-word byte.
// - register indirect uses low 24 bits of the address register.
// - displacement 16 sign-extended or 24 bits added; low 24 bits used.
// - post-increment address_add_op 1, 2 or 4 to full register after access.
// - pre-decrement subtracts 1, 2 or 4 first, writes back, uses low 24.
// - 8-bit absolute forces upper bits to one: window FF00 to FFFF.
// - 16-bit absolute fills upper eight bits by sign extension.
// - 24-bit absolute reaches the whole 0000 to FFFF space.
// - immediate mode passes 8, 16 or 32-bit constant as operand.
// - implicit step immediates for address add/subtract; 2-bit trap vector.
// - pc relative sign-extends 8 or 16-bit displacement onto next pc.
// - memory indirect: absolute jump/call only; pc relative: relative call.
// - memory indirect reads a longword, drops first byte, 24-bit target.
// - memory indirect pointer has upper bits zero: 0000 to 00FF.
// - 24-bit values enter 32-bit arithmetic with top byte zero.
module eag_core (
	// clock, reset, enable
	input  wire logic                 ref_clk,
	input  wire logic                 sys_rst,
	input  wire logic                 clk_en,
	// decoded request
	input  wire logic                 req_valid,
	input  wire eag_pkg::eag_class_t  op_class,
	input  wire eag_pkg::eag_mode_t   ea_mode,
	input  wire eag_pkg::eag_width_t  ext_width,
	input  wire eag_pkg::eag_size_t   acc_size,
	input  wire logic [3:0]           reg_sel,
	input  wire logic [31:0]          ext_field,
	input  wire logic [23:0]          pc_next,
	input  wire logic                 bit_from_reg,
	input  wire logic [3:0]           bit_reg_sel,
	input  wire logic [2:0]           bit_imm,
	input  wire logic                 access_done,
	// register bank load port
	input  wire logic                 reg_wr_en,
	input  wire logic [2:0]           reg_wr_idx,
	input  wire logic [31:0]          reg_wr_data,
	// memory indirect fetch
	input  wire logic                 mem_rd_ack,
	input  wire logic [31:0]          mem_rd_data,
	output logic                      mem_rd_req,
	output logic [15:0]               mem_rd_addr,
	// results
	output logic                      ea_busy,
	output logic                      ea_valid,
	output logic                      ea_illegal,
	output logic [15:0]               ea_addr,
	output logic [15:0]               branch_target,
	output logic [31:0]               operand_value,
	output logic [2:0]                bit_num
);
	import eag_pkg::*;

	typedef struct packed {
		eag_state_t                    state;
		logic [EAG_NREG-1:0][31:0]     regs;
		logic                          busy;
		logic                          valid;
		logic                          illegal;
		logic [15:0]                   addr;
		logic [15:0]                   target;
		logic [31:0]                   operand;
		logic [2:0]                    bitn;
		logic                          rd_req;
		logic [15:0]                   rd_addr;
		logic [31:0]                   wb_val;
		logic [2:0]                    wb_idx;
		eag_mode_t                     mode;
		eag_class_t                    opc;
		eag_width_t                    width;
		eag_size_t                     size;
	} eag_st_t;

	localparam eag_st_t EAG_ST_RST = '0;

	eag_st_t q;
	eag_st_t d;

	// which modes each class may use; also read by the checks below
	function automatic logic eag_allowed(eag_class_t c, eag_mode_t m);
		case (c)
			EAG_C_ARITH:    return m == EAG_M_REG_DIRECT || m == EAG_M_IMM;
			EAG_C_XFER:     return m != EAG_M_PC_REL && m != EAG_M_MEM_IND &&
			                       m <= EAG_M_MEM_IND;
			EAG_C_BIT:      return m == EAG_M_REG_DIRECT || m == EAG_M_REG_IND ||
			                       m == EAG_M_ABS;
			EAG_C_JUMP:     return m == EAG_M_REG_IND || m == EAG_M_ABS ||
			                       m == EAG_M_MEM_IND;
			EAG_C_RCALL:    return m == EAG_M_PC_REL;
			EAG_C_IMPLICIT: return m == EAG_M_REG_DIRECT;
			EAG_C_TRAP:     return m == EAG_M_IMM;
			default:        return 1'b0;
		endcase
	endfunction : eag_allowed

	// step for stepping modes and implicit immediates
	function automatic logic [31:0] eag_step(eag_size_t s);
		case (s)
			EAG_SZ_BYTE: return EAG_STEP_BYTE;
			EAG_SZ_WORD: return EAG_STEP_WORD;
			default:     return EAG_STEP_LONG;
		endcase
	endfunction : eag_step

	// byte register pick: sel[3] low chooses the high byte of the low word
	function automatic logic [7:0] eag_byte(logic [31:0] r, logic hi_n);
		return hi_n ? r[7:0] : r[15:8];
	endfunction : eag_byte

	logic        take;
	logic        ok;
	logic [31:0] sel_reg;
	logic [23:0] disp24;
	logic [31:0] disp_sum;
	logic [23:0] ea24;
	logic [7:0]  bit_byte;

	assign take = req_valid && !q.busy;
	// bit number source byte, same byte coding as register direct
	assign bit_byte = eag_byte(q.regs[bit_reg_sel[2:0]], bit_reg_sel[3]);
	assign ok   = eag_allowed(op_class, ea_mode);
	assign sel_reg = q.regs[reg_sel[2:0]];

	// displacement for register indirect: 16-bit is sign extended
	assign disp24 = (ext_width == EAG_W16) ?
		{{8{ext_field[15]}}, ext_field[15:0]} : ext_field[23:0];
	assign disp_sum = sel_reg + {EAG_TOP_ZERO, disp24};

	// address per mode, formed combinationally from fields and registers
	always_comb begin
		case (ea_mode)
			EAG_M_REG_IND:  ea24 = sel_reg[23:0];
			EAG_M_REG_DISP: ea24 = disp_sum[23:0];
			EAG_M_POST_INC: ea24 = sel_reg[23:0];
			EAG_M_PRE_DEC:  ea24 = 24'(sel_reg - eag_step(acc_size));
			EAG_M_ABS: begin
				if (ext_width == EAG_W8)
					ea24 = {EAG_ABS8_FILL, ext_field[7:0]};
				else if (ext_width == EAG_W16)
					ea24 = {{8{ext_field[15]}}, ext_field[15:0]};
				else
					ea24 = ext_field[23:0];
			end
			EAG_M_PC_REL: begin
				if (ext_width == EAG_W8)
					ea24 = pc_next + {{16{ext_field[7]}}, ext_field[7:0]};
				else
					ea24 = pc_next + {{8{ext_field[15]}}, ext_field[15:0]};
			end
			EAG_M_MEM_IND:  ea24 = {EAG_IND_FILL, ext_field[7:0]};
			default:        ea24 = '0;
		endcase
	end

	// next state; an external load is overridden by a write-back to the
	// same register since the write-back is the architectural result
	always_comb begin
		d = q;
		d.valid = 1'b0;
		if (reg_wr_en)
			d.regs[reg_wr_idx] = reg_wr_data;
		case (q.state)
			EAG_S_IDLE: begin
				if (take) begin
					d.mode    = ea_mode;
					d.opc     = op_class;
					d.width   = ext_width;
					d.size    = acc_size;
					d.illegal = !ok;
					d.addr    = ea24[15:0];
					d.target  = ea24[15:0];
					d.wb_idx  = reg_sel[2:0];
					d.bitn    = bit_from_reg ? bit_byte[2:0] : bit_imm;
					d.operand = '0;
					if (!ok)
						d.valid = 1'b1;
					else if (ea_mode == EAG_M_MEM_IND) begin
						d.busy    = 1'b1;
						d.rd_req  = 1'b1;
						d.rd_addr = ea24[15:0];
						d.state   = EAG_S_FETCH;
					end else begin
						d.valid = 1'b1;
						case (ea_mode)
							EAG_M_REG_DIRECT: begin
								if (op_class == EAG_C_IMPLICIT)
									d.operand = eag_step(acc_size);
								else if (acc_size == EAG_SZ_BYTE)
									d.operand = {24'h000000,
										eag_byte(sel_reg, reg_sel[3])};
								else if (acc_size == EAG_SZ_WORD)
									d.operand = {16'h0000, reg_sel[3] ?
										sel_reg[31:16] : sel_reg[15:0]};
								else
									d.operand = sel_reg;
							end
							EAG_M_IMM: begin
								if (op_class == EAG_C_TRAP)
									d.operand = {30'h0, ext_field[1:0]};
								else if (ext_width == EAG_W8)
									d.operand = {24'h000000, ext_field[7:0]};
								else if (ext_width == EAG_W16)
									d.operand = {16'h0000, ext_field[15:0]};
								else
									d.operand = ext_field;
							end
							EAG_M_POST_INC: begin
								d.wb_val = sel_reg + eag_step(acc_size);
								d.busy   = 1'b1;
								d.state  = EAG_S_WAIT;
							end
							EAG_M_PRE_DEC: begin
								d.wb_val = sel_reg - eag_step(acc_size);
								d.busy   = 1'b1;
								d.state  = EAG_S_WAIT;
							end
							default: d.operand = '0;
						endcase
					end
				end
			end
			EAG_S_WAIT: begin
				// write-back lands on the edge that ends the operand access
				if (access_done) begin
					d.regs[q.wb_idx] = q.wb_val;
					d.busy  = 1'b0;
					d.state = EAG_S_IDLE;
				end
			end
			EAG_S_FETCH: begin
				if (mem_rd_ack) begin
					d.target = mem_rd_data[15:0];
					d.addr   = mem_rd_data[15:0];
					d.rd_req = 1'b0;
					d.busy   = 1'b0;
					d.valid  = 1'b1;
					d.state  = EAG_S_IDLE;
				end
			end
			default: d = EAG_ST_RST;
		endcase
	end

	// single state register; enable low freezes everything
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			q <= EAG_ST_RST;
		else if (clk_en)
			q <= d;
	end

	assign mem_rd_req    = q.rd_req;
	assign mem_rd_addr   = q.rd_addr;
	assign ea_busy       = q.busy;
	assign ea_valid      = q.valid;
	assign ea_illegal    = q.illegal;
	assign ea_addr       = q.addr;
	assign branch_target = q.target;
	assign operand_value = q.operand;
	assign bit_num       = q.bitn;

	// checks; a take needs clk_en so the result shows one edge later
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	a_abs8_window: assert property (clk_en && take && ok && ea_mode == EAG_M_ABS &&
		ext_width == EAG_W8 |=> ea_valid && ea_addr[15:8] == 8'hFF)
		else $error("abs8 address outside top page");
	a_abs24_trunc: assert property (clk_en && take && ok && ea_mode == EAG_M_ABS &&
		ext_width == EAG_W24 |=> {16'h0000, ea_addr} ==
		($past(ext_field) & 32'h0000FFFF))
		else $error("abs24 address not truncated to low 16 bits");
	a_mode_legal: assert property (ea_valid && q.opc == EAG_C_ARITH |->
		ea_illegal == !(q.mode == EAG_M_REG_DIRECT || q.mode == EAG_M_IMM))
		else $error("arithmetic operand mode not policed");
	a_refuse_quiet: assert property (ea_valid && ea_illegal |->
		!mem_rd_req && operand_value == 32'h0000_0000)
		else $error("refused request still fetched or gave an operand");
	a_post_inc_step: assert property (ea_valid && !ea_illegal &&
		q.mode == EAG_M_POST_INC && !$past(reg_wr_en) |->
		q.wb_val - q.regs[q.wb_idx] == (q.size == EAG_SZ_BYTE ?
		EAG_STEP_BYTE : q.size == EAG_SZ_WORD ? EAG_STEP_WORD :
		EAG_STEP_LONG) && ea_addr == q.regs[q.wb_idx][15:0])
		else $error("post-increment step wrong");
	a_pre_dec_addr: assert property (ea_valid && !ea_illegal &&
		q.mode == EAG_M_PRE_DEC |-> ea_addr == q.wb_val[15:0])
		else $error("pre-decrement address not the decremented value");
	a_ptr_page_zero: assert property (mem_rd_req |->
		mem_rd_addr[15:8] == EAG_TOP_ZERO)
		else $error("indirect pointer outside vector page");
	a_fetch_target: assert property (clk_en && mem_rd_req && mem_rd_ack |=>
		ea_valid && !mem_rd_req && {16'h0000, branch_target} ==
		($past(mem_rd_data) & 32'h0000FFFF))
		else $error("indirect target not taken from fetched data");
	a_wb_release: assert property (clk_en && q.state == EAG_S_WAIT &&
		access_done |=> !ea_busy && q.regs[$past(q.wb_idx)] == $past(q.wb_val))
		else $error("write-back missing at access end");

	c_post_inc: cover property (ea_valid && q.mode == EAG_M_POST_INC);
	c_mem_ind:  cover property (mem_rd_req && mem_rd_ack);
	c_illegal:  cover property (ea_valid && ea_illegal);

endmodule : eag_core

// [inc/eag_pkg.sv]
// eag_pkg: constants and types for the effective address generator.
// assumes the decoder supplies mode, field width and access size codes.
package eag_pkg;

	// addressing modes
	typedef enum logic [3:0] {
		EAG_M_REG_DIRECT = 4'h0,
		EAG_M_REG_IND    = 4'h1,
		EAG_M_REG_DISP   = 4'h2,
		EAG_M_POST_INC   = 4'h3,
		EAG_M_PRE_DEC    = 4'h4,
		EAG_M_ABS        = 4'h5,
		EAG_M_IMM        = 4'h6,
		EAG_M_PC_REL     = 4'h7,
		EAG_M_MEM_IND    = 4'h8
	} eag_mode_t;

	// instruction classes as seen by address generation
	typedef enum logic [2:0] {
		EAG_C_ARITH    = 3'h0,
		EAG_C_XFER     = 3'h1,
		EAG_C_BIT      = 3'h2,
		EAG_C_JUMP     = 3'h3, // absolute_jump_op / absolute_call_op
		EAG_C_RCALL    = 3'h4, // relative_call_op
		EAG_C_IMPLICIT = 3'h5, // address_add_op, address_subtract_op, steps
		EAG_C_TRAP     = 3'h6  // software_trap_op
	} eag_class_t;

	// width of the extension field
	typedef enum logic [1:0] {
		EAG_W8  = 2'h0,
		EAG_W16 = 2'h1,
		EAG_W24 = 2'h2,
		EAG_W32 = 2'h3
	} eag_width_t;

	// access size
	typedef enum logic [1:0] {
		EAG_SZ_BYTE = 2'h0,
		EAG_SZ_WORD = 2'h1,
		EAG_SZ_LONG = 2'h2
	} eag_size_t;

	// sequencer states
	typedef enum logic [1:0] {
		EAG_S_IDLE = 2'h0,
		EAG_S_WAIT = 2'h1,
		EAG_S_FETCH = 2'h2
	} eag_state_t;

	localparam logic [31:0] EAG_STEP_BYTE = 32'h0000_0001;
	localparam logic [31:0] EAG_STEP_WORD = 32'h0000_0002;
	localparam logic [31:0] EAG_STEP_LONG = 32'h0000_0004;
	localparam logic [15:0] EAG_ABS8_FILL = 16'hFFFF;
	localparam logic [15:0] EAG_IND_FILL  = 16'h0000;
	localparam logic [7:0]  EAG_TOP_ZERO  = 8'h00;
	localparam int          EAG_NREG      = 8;

endpackage : eag_pkg

// [test/eag_mem_model.sv]
// eag_mem_model: memory bus stand-in answering vector fetches.
// assumes one fetch at a time; lat sets the wait before the ack pulse.
`timescale 1ns/1ps
module eag_mem_model (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// fetch request from the generator
	input  wire logic        mem_rd_req,
	input  wire logic [15:0] mem_rd_addr,
	input  wire logic [3:0]  lat,
	// answer
	output logic             mem_rd_ack,
	output logic [31:0]      mem_rd_data
);
	logic [3:0] cnt_q;

	// data churns every cycle outside the ack so stale values never match
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			mem_rd_ack  <= 1'b0;
			cnt_q       <= 4'h0;
			mem_rd_data <= 32'h0000_0000;
		end else if (mem_rd_req && !mem_rd_ack && cnt_q >= lat) begin
			mem_rd_ack  <= 1'b1;
			cnt_q       <= 4'h0;
			mem_rd_data <= {8'hA5, 8'h5A, ~mem_rd_addr[7:0],
				mem_rd_addr[7:0]};
		end else begin
			mem_rd_ack  <= 1'b0;
			cnt_q       <= mem_rd_req ? cnt_q + 4'h1 : 4'h0;
			mem_rd_data <= mem_rd_data + 32'h1357_9BDF;
		end
	end
endmodule : eag_mem_model

// [test/testbench.sv]
// testbench: directed scenarios for the effective address generator.
// assumes eag_pkg is compiled first and the memory model is present.
`timescale 1ns/1ps
module testbench;
	import eag_pkg::*;
	// stimulus, all valued at time zero
	logic        ref_clk      = 1'b0;
	logic        sys_rst      = 1'b1;
	logic        clk_en       = 1'b1;
	logic        req_valid    = 1'b0;
	logic        bit_from_reg = 1'b0;
	logic        access_done  = 1'b0;
	logic        reg_wr_en    = 1'b0;
	eag_class_t  op_class     = EAG_C_ARITH;
	eag_mode_t   ea_mode      = EAG_M_REG_DIRECT;
	eag_width_t  ext_width    = EAG_W8;
	eag_size_t   acc_size     = EAG_SZ_BYTE;
	logic [3:0]  reg_sel      = 4'h0;
	logic [3:0]  bit_reg_sel  = 4'h0;
	logic [3:0]  lat          = 4'h0;
	logic [2:0]  bit_imm      = 3'h0;
	logic [2:0]  reg_wr_idx   = 3'h0;
	logic [23:0] pc_next      = 24'h00_0000;
	logic [31:0] ext_field    = 32'h0000_0000;
	logic [31:0] reg_wr_data  = 32'h0000_0000;
	// observed
	logic        mem_rd_ack, mem_rd_req, ea_busy, ea_valid, ea_illegal;
	logic [31:0] mem_rd_data, operand_value;
	logic [15:0] mem_rd_addr, ea_addr, branch_target, seen_addr;
	logic [2:0]  bit_num;
	int          miscompares  = 0;
	int          n_checks     = 0;
	int          cycles       = 0;

	eag_core u_eag_core (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.req_valid(req_valid), .op_class(op_class), .ea_mode(ea_mode),
		.ext_width(ext_width), .acc_size(acc_size), .reg_sel(reg_sel),
		.ext_field(ext_field), .pc_next(pc_next),
		.bit_from_reg(bit_from_reg), .bit_reg_sel(bit_reg_sel),
		.bit_imm(bit_imm), .access_done(access_done),
		.reg_wr_en(reg_wr_en), .reg_wr_idx(reg_wr_idx),
		.reg_wr_data(reg_wr_data), .mem_rd_ack(mem_rd_ack),
		.mem_rd_data(mem_rd_data), .mem_rd_req(mem_rd_req),
		.mem_rd_addr(mem_rd_addr), .ea_busy(ea_busy), .ea_valid(ea_valid),
		.ea_illegal(ea_illegal), .ea_addr(ea_addr),
		.branch_target(branch_target), .operand_value(operand_value),
		.bit_num(bit_num)
	);
	eag_mem_model u_eag_mem_model (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .mem_rd_req(mem_rd_req),
		.mem_rd_addr(mem_rd_addr), .lat(lat), .mem_rd_ack(mem_rd_ack),
		.mem_rd_data(mem_rd_data)
	);

	// 40 ns clock
	initial begin
		forever #20 ref_clk = ~ref_clk;
	end

	// hang guard, plus capture of the fetch address while it is asked
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (mem_rd_req === 1'b1)
			seen_addr <= mem_rd_addr;
		if (cycles == 3000) begin
			miscompares = miscompares + 1;
			tally_and_finish;
		end
	end

	task automatic tally_and_finish;
		if (miscompares == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish

	task automatic cmp(input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t: expected %h got %h", $time, e, g);
		end
	endtask : cmp

	task automatic ld(input logic [2:0] i, input logic [31:0] v);
		reg_wr_en = 1'b1;
		reg_wr_idx = i;
		reg_wr_data = v;
		@(posedge ref_clk);
		#2;
		reg_wr_en = 1'b0;
		// let an edge pass so a following load raises the strobe anew
		@(posedge ref_clk);
		#2;
	endtask : ld

	// one request, returns in the cycle ea_valid stands
	task automatic req(input eag_class_t c, input eag_mode_t m,
		input eag_width_t w, input eag_size_t s, input logic [3:0] r,
		input logic [31:0] e);
		op_class = c;
		ea_mode = m;
		ext_width = w;
		acc_size = s;
		reg_sel = r;
		ext_field = e;
		req_valid = 1'b1;
		@(posedge ref_clk);
		#2;
		req_valid = 1'b0;
		// except for memory indirect the pulse already stands right after the take edge; the loop waits out the fetch
		repeat (20) begin
			if (ea_valid === 1'b1)
				return;
			@(posedge ref_clk);
			#2;
		end
		cmp(32'h0000_0001, 32'h0000_0000);
	endtask : req

	task automatic done;
		access_done = 1'b1;
		@(posedge ref_clk);
		#2;
		access_done = 1'b0;
	endtask : done

	task automatic t_regdir;
		ld(3'h3, 32'h1234_5678);
		ld(3'h4, 32'h0000_0B0E);
		req(EAG_C_XFER, EAG_M_REG_DIRECT, EAG_W8, EAG_SZ_LONG, 4'h3, 0);
		cmp(32'h1234_5678, operand_value);
		req(EAG_C_XFER, EAG_M_REG_DIRECT, EAG_W8, EAG_SZ_WORD, 4'hB, 0);
		cmp(32'h0000_1234, operand_value);
		req(EAG_C_XFER, EAG_M_REG_DIRECT, EAG_W8, EAG_SZ_BYTE, 4'hB, 0);
		cmp(32'h0000_0078, operand_value);
		bit_imm = 3'h5;
		req(EAG_C_BIT, EAG_M_REG_DIRECT, EAG_W8, EAG_SZ_BYTE, 4'h4, 0);
		cmp(32'h0000_0005, 32'(bit_num));
		bit_from_reg = 1'b1;
		bit_reg_sel = 4'h4;
		req(EAG_C_BIT, EAG_M_REG_DIRECT, EAG_W8, EAG_SZ_BYTE, 4'h4, 0);
		cmp(32'h0000_0003, 32'(bit_num));
	endtask : t_regdir

	task automatic t_abs;
		req(EAG_C_XFER, EAG_M_ABS, EAG_W8, EAG_SZ_BYTE, 0, 32'h0000_0012);
		cmp(32'h0000_FF12, 32'(ea_addr));
		req(EAG_C_XFER, EAG_M_ABS, EAG_W16, EAG_SZ_BYTE, 0, 32'h0000_8034);
		cmp(32'h0000_8034, 32'(ea_addr));
		req(EAG_C_JUMP, EAG_M_ABS, EAG_W24, EAG_SZ_BYTE, 0, 32'h00AB_1234);
		cmp(32'h0000_1234, 32'(branch_target));
		ld(3'h1, 32'h0012_FFF0);
		req(EAG_C_XFER, EAG_M_REG_IND, EAG_W8, EAG_SZ_BYTE, 4'h1, 0);
		cmp(32'h0000_FFF0, 32'(ea_addr));
		req(EAG_C_XFER, EAG_M_REG_DISP, EAG_W16, EAG_SZ_BYTE, 4'h1, 'hFFF0);
		cmp(32'h0000_FFE0, 32'(ea_addr));
		req(EAG_C_XFER, EAG_M_REG_DISP, EAG_W24, EAG_SZ_BYTE, 4'h1, 'h20);
		cmp(32'h0000_0010, 32'(ea_addr));
	endtask : t_abs

	// steps cross the 24-bit carry, so the full register must be stepped
	task automatic t_step;
		logic [31:0] a;
		a = 32'h00FF_FFFC;
		ld(3'h2, a);
		for (int i = 0; i < 3; i++) begin
			req(EAG_C_XFER, EAG_M_POST_INC, EAG_W8, eag_size_t'(2 - i), 4'h2, 0);
			cmp(a, 32'(ea_addr) | (a & 32'hFFFF_0000));
			cmp(32'h0000_0001, 32'(ea_busy));
			done;
			a = a + (32'h1 << (2 - i));
		end
		for (int i = 0; i < 3; i++) begin
			a = a - (32'h1 << i);
			req(EAG_C_XFER, EAG_M_PRE_DEC, EAG_W8, eag_size_t'(i), 4'h2, 0);
			cmp(a & 32'h0000_FFFF, 32'(ea_addr));
			done;
		end
		req(EAG_C_XFER, EAG_M_REG_IND, EAG_W8, EAG_SZ_BYTE, 4'h2, 0);
		cmp(32'h0000_FFFC, 32'(ea_addr));
	endtask : t_step

	task automatic t_branch;
		pc_next = 24'h00_1000;
		req(EAG_C_RCALL, EAG_M_PC_REL, EAG_W8, EAG_SZ_WORD, 0, 'h80);
		cmp(32'h0000_0F80, 32'(branch_target));
		req(EAG_C_RCALL, EAG_M_PC_REL, EAG_W16, EAG_SZ_WORD, 0, 'h7FFE);
		cmp(32'h0000_8FFE, 32'(branch_target));
		for (int i = 0; i < 2; i++) begin
			lat = 4'(3 * i);
			req(EAG_C_JUMP, EAG_M_MEM_IND, EAG_W8, EAG_SZ_LONG, 0, 'h5A40);
			cmp(32'h0000_0040, 32'(seen_addr));
			cmp(32'h0000_BF40, 32'(branch_target));
		end
	endtask : t_branch

	// class and mode pairs: class, mode, refused flag
	task automatic t_legal;
		logic [7:0] tbl [9] = '{8'h0B, 8'h0C, 8'h2F, 8'h31, 8'h45, 8'h42,
			8'h8B, 8'h6F, 8'h62};
		foreach (tbl[i]) begin
			req(eag_class_t'(tbl[i][7:5]), eag_mode_t'(tbl[i][4:1]), EAG_W8,
				EAG_SZ_BYTE, 0, 0);
			cmp(32'(tbl[i][0]), 32'(ea_illegal));
		end
		req(EAG_C_ARITH, EAG_M_IMM, EAG_W16, EAG_SZ_WORD, 0, 'hCAFE_12A5);
		cmp(32'h0000_12A5, operand_value);
		req(EAG_C_ARITH, EAG_M_IMM, EAG_W32, EAG_SZ_LONG, 0, 'hCAFE_12A5);
		cmp(32'hCAFE_12A5, operand_value);
		for (int i = 0; i < 3; i++) begin
			req(EAG_C_IMPLICIT, EAG_M_REG_DIRECT, EAG_W8, eag_size_t'(i), 0, 0);
			cmp(32'h1 << i, operand_value);
		end
		req(EAG_C_TRAP, EAG_M_IMM, EAG_W8, EAG_SZ_BYTE, 0, 'h7);
		cmp(32'h0000_0003, operand_value);
	endtask : t_legal

	// enable low must hold all state, a pending request included
	task automatic t_freeze;
		@(posedge ref_clk);
		#2;
		clk_en = 1'b0;
		op_class = EAG_C_ARITH;
		ea_mode = EAG_M_IMM;
		ext_width = EAG_W8;
		ext_field = 32'h0000_00C3;
		req_valid = 1'b1;
		repeat (3) @(posedge ref_clk);
		#2;
		cmp(32'h0000_0000, 32'(ea_valid));
		cmp(32'h0000_0003, operand_value);
		clk_en = 1'b1;
		@(posedge ref_clk);
		#2;
		req_valid = 1'b0;
		cmp(32'h0000_0001, 32'(ea_valid));
		cmp(32'h0000_00C3, operand_value);
	endtask : t_freeze

	// main sequence
	initial begin
		repeat (8) @(posedge ref_clk);
		#2;
		sys_rst = 1'b0;
		t_regdir;
		t_abs;
		t_step;
		t_branch;
		t_legal;
		t_freeze;
		tally_and_finish;
	end
endmodule : testbench
